// ===== core/psa_core.sv
// PMBus status aggregation: seven-byte status block and phased fault summary.
module psa_core #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          link_clk,
  input  wire logic                          smb_clk_in,
  input  wire logic                          smb_dat_in,
  output logic                               smb_dat_out,
  output logic                               smb_dat_oe_n,
  output logic                               smb_alert_out,
  output logic                               smb_alert_oe_n,
  input  wire psa_pkg::psa_status_t          status_in,
  input  wire psa_pkg::psa_phase_cfg_t [3:0] phase_cfg,
  input  wire logic [3:0]                    phase_fault,
  input  wire logic [3:0][15:0]              phase_detail,
  input  wire logic                          clear_faults,
  output logic                               cml_flag_out,
  output logic                               invalid_command_flag
);

  // System clock domain.
  logic [1:0]           sys_s;
  logic                 req_seen_reg;
  logic                 evt_seen_reg;
  logic                 snap_take;
  logic                 evt_take;
  logic [7:0]           phase_sel_reg;
  logic                 inv_cmd_reg;
  logic [3:0]           sum_flag_reg;
  logic [3:0]           sum_clr;
  logic [3:0]           used_mask;
  logic [3:0]           raw_flags;
  logic [15:0]          detail_word;
  logic                 summary_mode;
  logic [15:0]          word_mux;
  psa_pkg::psa_status_t live_status;
  psa_pkg::psa_status_t snap_status_reg;
  logic [15:0]          snap_word_reg;
  logic [7:0]           snap_phase_reg;
  logic                 ack_tgl_reg;
  logic                 alert_oe_n_reg;
  logic                 cml_flag_reg;

  // Link clock domain.
  logic [3:0]           link_s;
  logic                 lrst;
  logic                 scl;
  logic                 sda;
  logic                 ack_s;
  logic                 scl_d_reg;
  logic                 sda_d_reg;
  logic                 start_c;
  logic                 stop_c;
  logic                 rise;
  logic                 fall;
  logic                 byte_done;
  logic [7:0]           rx_next;
  psa_pkg::psa_state_t  state_reg;
  logic [3:0]           cnt_reg;
  logic [7:0]           rx_reg;
  logic [7:0]           cmd_reg;
  logic [3:0]           idx_reg;
  logic [7:0]           low_byte_reg;
  logic [7:0]           tx_reg;
  logic [7:0]           tx_next;
  logic [2:0]           byte_sel;
  logic                 ack_pend_reg;
  logic                 dat_oe_n_reg;
  logic                 req_tgl_reg;
  logic                 evt_tgl_reg;
  psa_pkg::psa_evt_t    evt_reg;
  logic                 ack_seen_reg;
  psa_pkg::psa_status_t lsnap_status_reg;
  logic [15:0]          lsnap_word_reg;
  logic [7:0]           lsnap_phase_reg;

  // ---------------- System clock domain ----------------

  psa_sync2 #(.W(2)) u_sys_sync (
    .clk (clk_sys),
    .d   ({req_tgl_reg, evt_tgl_reg}),
    .q   (sys_s)
  );

  assign snap_take = sys_s[1] ^ req_seen_reg;
  assign evt_take  = sys_s[0] ^ evt_seen_reg;

  psa_phase_map u_map (
    .phase_cfg    (phase_cfg),
    .phase_fault  (phase_fault),
    .phase_detail (phase_detail),
    .phase_sel    (phase_sel_reg),
    .used_mask    (used_mask),
    .raw_flags    (raw_flags),
    .detail_word  (detail_word)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_seen_reg <= 1'b0;
      evt_seen_reg <= 1'b0;
    end else begin
      req_seen_reg <= sys_s[1];
      evt_seen_reg <= sys_s[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_sel_reg <= psa_pkg::PHASE_RESET;
    end else if (evt_take && evt_reg.kind == psa_pkg::EVT_PHASE) begin
      phase_sel_reg <= evt_reg.lo;
    end
  end

  // A new invalid-command event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inv_cmd_reg <= 1'b0;
    end else begin
      inv_cmd_reg <= (evt_take && evt_reg.kind == psa_pkg::EVT_INV_CMD)
                     || (inv_cmd_reg && !clear_faults);
    end
  end

  assign sum_clr = (evt_take && evt_reg.kind == psa_pkg::EVT_SUMMARY)
                   ? evt_reg.lo[3:0] : 4'h0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sum_flag_reg <= psa_pkg::SUMMARY_RESET[3:0];
    end else begin
      sum_flag_reg <= raw_flags | (sum_flag_reg & ~sum_clr & ~{4{clear_faults}});
    end
  end

  always_comb begin
    live_status     = status_in;
    live_status.cml = status_in.cml | (inv_cmd_reg ? psa_pkg::CML_INV_MASK : 8'h00);
  end

  assign summary_mode = (phase_sel_reg == psa_pkg::PHASE_ALL)
                        || (phase_sel_reg == psa_pkg::PHASE_ALL_ALT);
  assign word_mux = summary_mode ? {{psa_pkg::SUM_RSVD_W{1'b0}}, sum_flag_reg & used_mask}
                                 : detail_word;

  // The snapshot holds still between requests, so the link side may copy it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snap_status_reg <= '0;
      snap_word_reg   <= psa_pkg::SUMMARY_RESET;
      snap_phase_reg  <= psa_pkg::PHASE_RESET;
      ack_tgl_reg     <= 1'b0;
    end else if (snap_take) begin
      snap_status_reg <= live_status;
      snap_word_reg   <= word_mux;
      snap_phase_reg  <= phase_sel_reg;
      ack_tgl_reg     <= ~ack_tgl_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alert_oe_n_reg <= 1'b1;
      cml_flag_reg   <= 1'b0;
    end else begin
      alert_oe_n_reg <= ~inv_cmd_reg;
      cml_flag_reg   <= |live_status.cml;
    end
  end

  assign smb_alert_out        = 1'b0;
  assign smb_alert_oe_n       = alert_oe_n_reg;
  assign cml_flag_out         = cml_flag_reg;
  assign invalid_command_flag = inv_cmd_reg;

  // ---------------- Link clock domain ----------------

  psa_sync2 #(.W(4)) u_link_sync (
    .clk (link_clk),
    .d   ({rst, smb_clk_in, smb_dat_in, ack_tgl_reg}),
    .q   (link_s)
  );

  assign lrst      = link_s[3];
  assign scl       = link_s[2];
  assign sda       = link_s[1];
  assign ack_s     = link_s[0];
  assign start_c   = scl && scl_d_reg && sda_d_reg && !sda;
  assign stop_c    = scl && scl_d_reg && !sda_d_reg && sda;
  assign rise      = scl && !scl_d_reg;
  assign fall      = !scl && scl_d_reg;
  assign rx_next   = {rx_reg[6:0], sda};
  assign byte_done = rise && (cnt_reg == psa_pkg::BIT_LAST_DATA)
                     && (state_reg inside {psa_pkg::ST_ADDR, psa_pkg::ST_CMD,
                                           psa_pkg::ST_WDATA});

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      state_reg <= psa_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
    end else if (start_c) begin
      state_reg <= psa_pkg::ST_ADDR;
      cnt_reg   <= 4'h0;
    end else if (stop_c) begin
      state_reg <= psa_pkg::ST_IDLE;
    end else begin
      if (rise) begin
        cnt_reg <= (cnt_reg == psa_pkg::BIT_ACK_SLOT) ? 4'h0 : cnt_reg + 4'h1;
      end
      unique case (state_reg)
        psa_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (rx_next[7:1] != DEV_ADDR) begin
              state_reg <= psa_pkg::ST_IDLE;
            end else if (rx_next[0]) begin
              state_reg <= psa_pkg::ST_RDATA;
            end else begin
              state_reg <= psa_pkg::ST_CMD;
            end
          end
        end
        psa_pkg::ST_CMD: begin
          if (byte_done) begin
            state_reg <= psa_pkg::ST_WDATA;
          end
        end
        psa_pkg::ST_RDATA: begin
          if (rise && cnt_reg == psa_pkg::BIT_ACK_SLOT && sda) begin
            state_reg <= psa_pkg::ST_WAIT;
          end
        end
        psa_pkg::ST_IDLE, psa_pkg::ST_WDATA, psa_pkg::ST_WAIT: begin
          state_reg <= state_reg;
        end
        default: state_reg <= psa_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      rx_reg <= 8'h00;
    end else if (rise && cnt_reg < psa_pkg::BIT_ACK_SLOT) begin
      rx_reg <= rx_next;
    end
  end

  // Command byte: latch it and ask the system side for a fresh snapshot.
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      cmd_reg     <= 8'h00;
      req_tgl_reg <= 1'b0;
    end else if (byte_done && state_reg == psa_pkg::ST_CMD) begin
      cmd_reg     <= rx_next;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ack_seen_reg     <= 1'b0;
      lsnap_status_reg <= '0;
      lsnap_word_reg   <= psa_pkg::SUMMARY_RESET;
      lsnap_phase_reg  <= psa_pkg::PHASE_RESET;
    end else if (ack_s != ack_seen_reg) begin
      ack_seen_reg     <= ack_s;
      lsnap_status_reg <= snap_status_reg;
      lsnap_word_reg   <= snap_word_reg;
      lsnap_phase_reg  <= snap_phase_reg;
    end
  end

  assign byte_sel = 3'(idx_reg - 4'h1);

  always_comb begin
    tx_next = psa_pkg::IDLE_BYTE;
    if (cmd_reg == psa_pkg::CMD_AGG_STATUS) begin
      if (idx_reg == 4'h0) begin
        tx_next = psa_pkg::BLOCK_COUNT;
      end else if (idx_reg <= psa_pkg::BLOCK_LAST_IDX) begin
        tx_next = lsnap_status_reg[8*byte_sel +: 8];
      end
    end else if (cmd_reg == psa_pkg::CMD_PHASE_SUM) begin
      if (idx_reg == 4'h0) begin
        tx_next = lsnap_word_reg[7:0];
      end else if (idx_reg == 4'h1) begin
        tx_next = lsnap_word_reg[15:8];
      end
    end else if (cmd_reg == psa_pkg::CMD_PHASE && idx_reg == 4'h0) begin
      tx_next = lsnap_phase_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst || start_c) begin
      idx_reg <= 4'h0;
      tx_reg  <= psa_pkg::IDLE_BYTE;
    end else if (fall && cnt_reg == 4'h0 && state_reg == psa_pkg::ST_RDATA) begin
      tx_reg  <= tx_next;
      idx_reg <= (idx_reg == 4'hf) ? idx_reg : idx_reg + 4'h1;
    end else if (byte_done && state_reg == psa_pkg::ST_WDATA) begin
      idx_reg <= (idx_reg == 4'hf) ? idx_reg : idx_reg + 4'h1;
    end
  end

  // Data line: acknowledge slots, then read bits; released everywhere else.
  always_ff @(posedge link_clk) begin
    if (lrst || start_c || stop_c) begin
      dat_oe_n_reg <= 1'b1;
      ack_pend_reg <= 1'b0;
    end else if (byte_done) begin
      ack_pend_reg <= (state_reg != psa_pkg::ST_ADDR) || (rx_next[7:1] == DEV_ADDR);
    end else if (fall) begin
      if (cnt_reg == psa_pkg::BIT_ACK_SLOT && ack_pend_reg) begin
        dat_oe_n_reg <= 1'b0;
        ack_pend_reg <= 1'b0;
      end else if (state_reg == psa_pkg::ST_RDATA && cnt_reg == 4'h0) begin
        dat_oe_n_reg <= tx_next[7];
      end else if (state_reg == psa_pkg::ST_RDATA && cnt_reg != psa_pkg::BIT_ACK_SLOT) begin
        dat_oe_n_reg <= tx_reg[3'(psa_pkg::BIT_LAST_DATA - cnt_reg)];
      end else begin
        dat_oe_n_reg <= 1'b1;
      end
    end
  end

  assign smb_dat_out  = 1'b0;
  assign smb_dat_oe_n = dat_oe_n_reg;

  // Written data goes across as a held word plus a toggle.
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      evt_reg      <= '0;
      evt_tgl_reg  <= 1'b0;
      low_byte_reg <= 8'h00;
    end else if (byte_done && state_reg == psa_pkg::ST_WDATA) begin
      if (cmd_reg == psa_pkg::CMD_AGG_STATUS) begin
        evt_reg     <= '{psa_pkg::EVT_INV_CMD, rx_next, 8'h00};
        evt_tgl_reg <= ~evt_tgl_reg;
      end else if (cmd_reg == psa_pkg::CMD_PHASE && idx_reg == 4'h0) begin
        evt_reg     <= '{psa_pkg::EVT_PHASE, rx_next, 8'h00};
        evt_tgl_reg <= ~evt_tgl_reg;
      end else if (cmd_reg == psa_pkg::CMD_PHASE_SUM && idx_reg == 4'h0) begin
        low_byte_reg <= rx_next;
      end else if (cmd_reg == psa_pkg::CMD_PHASE_SUM && idx_reg == 4'h1) begin
        evt_reg     <= '{psa_pkg::EVT_SUMMARY, low_byte_reg, rx_next};
        evt_tgl_reg <= ~evt_tgl_reg;
      end
    end
  end

  // ---------------- Checks ----------------

  chk_block_count: assert property (@(posedge link_clk) disable iff (lrst)
    (fall && cnt_reg == 4'h0 && state_reg == psa_pkg::ST_RDATA && idx_reg == 4'h0
     && cmd_reg == psa_pkg::CMD_AGG_STATUS && !start_c && !stop_c)
    |=> (tx_reg == psa_pkg::BLOCK_COUNT))
    else $error("block read did not open with count seven");

  chk_pack_order: assert property (@(posedge clk_sys) disable iff (rst)
    snap_take |=> (snap_status_reg[7:0] == $past(status_in.vout))
                  && (snap_status_reg[55:48] == $past(status_in.mfr)))
    else $error("status block byte order wrong");

  chk_inv_cmd_set: assert property (@(posedge clk_sys) disable iff (rst)
    (evt_take && evt_reg.kind == psa_pkg::EVT_INV_CMD) |=> inv_cmd_reg ##1 cml_flag_out)
    else $error("invalid command write not flagged");

  chk_alert_drive: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(inv_cmd_reg) |=> !smb_alert_oe_n)
    else $error("alert not driven after invalid command");

  chk_no_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (inv_cmd_reg && !clear_faults) |=> inv_cmd_reg)
    else $error("status write cleared invalid command flag");

  chk_phase_write: assert property (@(posedge clk_sys) disable iff (rst)
    (evt_take && evt_reg.kind == psa_pkg::EVT_PHASE) |=> phase_sel_reg == $past(evt_reg.lo))
    else $error("phase selection not updated");

  chk_summary_view: assert property (@(posedge clk_sys) disable iff (rst)
    summary_mode |-> word_mux[3:0] == (sum_flag_reg & used_mask))
    else $error("summary word does not show phase flags");

  chk_detail_view: assert property (@(posedge clk_sys) disable iff (rst)
    !summary_mode |-> word_mux == detail_word)
    else $error("selected phase word not returned");

  chk_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
    summary_mode |-> (word_mux[3:0] & ~used_mask) == 4'h0)
    else $error("unused phase bit reads one");

  chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst)
    summary_mode |-> word_mux[15:4] == 12'h000)
    else $error("reserved summary bits not zero");

  chk_snap_live: assert property (@(posedge clk_sys) disable iff (rst)
    snap_take |=> snap_word_reg == $past(word_mux) && ack_tgl_reg != $past(ack_tgl_reg))
    else $error("snapshot not taken from live state");

endmodule // psa_core

// ===== core/psa_pkg.sv
// Shared constants and types for the PMBus status aggregation block.
package psa_pkg;

  localparam logic [7:0]  CMD_PHASE        = 8'h00;
  localparam logic [7:0]  CMD_AGG_STATUS   = 8'hdb;
  localparam logic [7:0]  CMD_PHASE_SUM    = 8'hdc;

  localparam int          NUM_PHASES       = 4;
  localparam int          SUM_RSVD_W       = 12;
  localparam logic [7:0]  BLOCK_COUNT      = 8'h07;
  localparam logic [3:0]  BLOCK_LAST_IDX   = 4'h7;
  localparam logic [3:0]  BIT_ACK_SLOT     = 4'h8;
  localparam logic [3:0]  BIT_LAST_DATA    = 4'h7;

  localparam logic [7:0]  PHASE_ALL        = 8'hff;
  localparam logic [7:0]  PHASE_ALL_ALT    = 8'h80;
  localparam logic [7:0]  PHASE_RESET      = 8'hff;
  localparam logic [7:0]  CML_INV_MASK     = 8'h80;
  localparam logic [15:0] SUMMARY_RESET    = 16'h0000;
  localparam logic [7:0]  IDLE_BYTE        = 8'hff;

  localparam logic [1:0]  EVT_PHASE        = 2'h1;
  localparam logic [1:0]  EVT_SUMMARY      = 2'h2;
  localparam logic [1:0]  EVT_INV_CMD      = 2'h3;

  // Packed so that output-voltage status lands in bits 7:0.
  typedef struct packed {
    logic [7:0] mfr;
    logic [7:0] other;
    logic [7:0] cml;
    logic [7:0] temperature;
    logic [7:0] input_st;
    logic [7:0] iout;
    logic [7:0] vout;
  } psa_status_t;

  typedef struct packed {
    logic       en;
    logic [1:0] num;
  } psa_phase_cfg_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] lo;
    logic [7:0] hi;
  } psa_evt_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_CMD   = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_WAIT  = 6'h20
  } psa_state_t;

endpackage

// ===== core/psa_sync2.sv
// Two-flop synchroniser for levels and toggles entering a clock domain.
module psa_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg    <= meta_reg;
  end

  assign q = q_reg;

endmodule // psa_sync2

// ===== core/psa_phase_map.sv
// Maps stacked devices onto phase numbers for the fault summary word.
module psa_phase_map (
  input  wire psa_pkg::psa_phase_cfg_t [3:0] phase_cfg,
  input  wire logic [3:0]                    phase_fault,
  input  wire logic [3:0][15:0]              phase_detail,
  input  wire logic [7:0]                    phase_sel,
  output logic      [3:0]                    used_mask,
  output logic      [3:0]                    raw_flags,
  output logic      [15:0]                   detail_word
);

  logic [3:0][3:0]  match;
  logic [3:0][15:0] masked;

  genvar n, d;
  generate
    for (n = 0; n < psa_pkg::NUM_PHASES; n++) begin : g_num
      for (d = 0; d < psa_pkg::NUM_PHASES; d++) begin : g_dev
        assign match[n][d] = phase_cfg[d].en && (phase_cfg[d].num == 2'(n));
      end
      assign used_mask[n] = |match[n];
      assign raw_flags[n] = |(match[n] & phase_fault);
    end
    for (d = 0; d < psa_pkg::NUM_PHASES; d++) begin : g_pick
      assign masked[d] = (phase_cfg[d].en && phase_sel == {6'h00, phase_cfg[d].num})
                         ? phase_detail[d] : 16'h0000;
    end
  endgenerate

  always_comb begin
    detail_word = 16'h0000;
    for (int i = 0; i < psa_pkg::NUM_PHASES; i++) begin
      detail_word = detail_word | masked[i];
    end
  end

endmodule // psa_phase_map

// ===== dv/psa_host_model.sv
// Behavioural PMBus host that drives SMBCLK and pulls SMBDAT like an open-drain master.
module psa_host_model (
  input  wire logic clk_sys,
  input  wire logic dev_oe_n,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Each SCL phase lasts 500 ns, the four link clocks the device needs; it keeps the run short.
  localparam int HALF = 100;
  logic          pull;
  // The data line has a pull-up, so it sits high unless a party pulls it low.
  assign sda = !(pull || !dev_oe_n);
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  task automatic hb();
    repeat (HALF) @(posedge clk_sys);
    #1;
  endtask
  // Serves both as START and as repeated START.
  task automatic start();
    pull = 1'b0;
    hb();
    scl = 1'b1;
    hb();
    pull = 1'b1;
    hb();
    scl = 1'b0;
  endtask
  task automatic stop();
    pull = 1'b1;
    hb();
    scl = 1'b1;
    hb();
    pull = 1'b0;
    hb();
  endtask
  // Nine bit slots; the line is sampled at the end of SCL high, where device data has settled.
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      pull = !w[i];
      hb();
      scl = 1'b1;
      hb();
      r[i] = sda;
      scl  = 1'b0;
    end
  endtask
endmodule // psa_host_model

// ===== dv/tb_top.sv
// Self-checking bench for the PMBus status aggregation block.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h10;
  logic                              clk_sys = 1'b0;
  logic                              link_clk = 1'b0;
  logic                              rst = 1'b1;
  logic                              scl;
  logic                              sda;
  logic                              oe_n;
  logic                              alert_n;
  logic                              dat_o;
  logic                              alert_o;
  logic                              cml;
  logic                              inv_cmd;
  logic                              clear_faults = 1'b0;
  logic [3:0]                        phase_fault = 4'h0;
  logic [3:0][15:0]                  detail;
  psa_pkg::psa_status_t              status;
  psa_pkg::psa_status_t              exp_st;
  psa_pkg::psa_phase_cfg_t [3:0]     cfg;
  int                                num_errors = 0;
  int                                num_checks = 0;
  int                                seed = 46;
  always #2.5 clk_sys = ~clk_sys;
  initial begin
    #1.7;
    forever #62.5 link_clk = ~link_clk;
  end
  psa_core #(.DEV_ADDR(ADDR)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk), .smb_clk_in(scl), .smb_dat_in(sda),
    .smb_dat_out(dat_o), .smb_dat_oe_n(oe_n), .smb_alert_out(alert_o), .smb_alert_oe_n(alert_n),
    .status_in(status), .phase_cfg(cfg), .phase_fault(phase_fault), .phase_detail(detail),
    .clear_faults(clear_faults), .cml_flag_out(cml), .invalid_command_flag(inv_cmd)
  );
  psa_host_model u_host (.clk_sys(clk_sys), .dev_oe_n(oe_n), .scl(scl), .sda(sda));
  function automatic logic [15:0] exp_sum(input logic [3:0] f);
    exp_sum = 16'h0000;
    for (int d = 0; d < 4; d++) begin
      if (cfg[d].en && f[d]) exp_sum[cfg[d].num] = 1'b1;
    end
  endfunction
  task automatic addr_cmd(input logic [7:0] cmd);
    logic [8:0] r;
    u_host.start();
    u_host.xfer({ADDR, 1'b0, 1'b1}, r);
    `CHK("address ack", 1'b0, r[0])
    u_host.xfer({cmd, 1'b1}, r);
  endtask
  task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
    logic [8:0] r;
    addr_cmd(cmd);
    for (int i = 0; i < n; i++) u_host.xfer({d[8*i +: 8], 1'b1}, r);
    u_host.stop();
  endtask
  // The host acknowledges every byte but the last, which it refuses to end the read.
  task automatic rd(input logic [7:0] cmd, input int n, output logic [63:0] d);
    logic [8:0] r;
    d = '0;
    addr_cmd(cmd);
    u_host.start();
    u_host.xfer({ADDR, 1'b1, 1'b1}, r);
    for (int i = 0; i < n; i++) begin
      u_host.xfer({8'hff, i == n - 1}, r);
      d[8*i +: 8] = r[8:1];
    end
    u_host.stop();
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #460000;
    num_errors++;
    end_of_test();
  end
  initial begin
    logic [63:0] d;
    logic [3:0]  f;
    logic [15:0] m;
    int          dis;
    int          k;
    dis    = $unsigned($random(seed)) % 4;
    k      = (dis + 1) % 4;
    status = 56'({$random(seed), $random(seed)});
    status.cml = 8'h00;
    for (int i = 0; i < 4; i++) begin
      cfg[i]    = '{en: (i != dis), num: 2'(i + dis)};
      detail[i] = 16'($random(seed));
    end
    f = 4'($random(seed)) | 4'(1 << dis);
    repeat (12) @(posedge link_clk);
    @(posedge clk_sys);
    #1 rst = 1'b0;
    `CHK("alert after reset", 1'b1, alert_n)
    `CHK("invalid after reset", 1'b0, inv_cmd)
    `CHK("open drain levels", 2'b00, {dat_o, alert_o})
    phase_fault = f;
    repeat (4) @(posedge clk_sys);
    #1 phase_fault = 4'h0;
    rd(psa_pkg::CMD_PHASE_SUM, 2, d);
    `CHK("summary all", exp_sum(f), d[15:0])
    `CHK("cml before", 1'b0, cml)
    wr(psa_pkg::CMD_AGG_STATUS, 1, 16'($random(seed)));
    `CHK("invalid flag", 1'b1, inv_cmd)
    `CHK("cml bit", 1'b1, cml)
    `CHK("alert low", 1'b0, alert_n)
    status = 56'({$random(seed), $random(seed)});
    exp_st = status;
    exp_st.cml[7] = 1'b1;
    rd(psa_pkg::CMD_AGG_STATUS, 8, d);
    `CHK("block count", 8'h07, d[7:0])
    `CHK("block bytes", exp_st, d[63:8])
    m = 16'(4'($random(seed)));
    wr(psa_pkg::CMD_PHASE, 1, 16'h0080);
    wr(psa_pkg::CMD_PHASE_SUM, 2, m);
    rd(psa_pkg::CMD_PHASE_SUM, 2, d);
    `CHK("summary alt", exp_sum(f) & ~m, d[15:0])
    wr(psa_pkg::CMD_PHASE, 1, 16'(cfg[k].num));
    rd(psa_pkg::CMD_PHASE, 1, d);
    `CHK("phase readback", 8'(cfg[k].num), d[7:0])
    rd(psa_pkg::CMD_PHASE_SUM, 2, d);
    `CHK("phase detail", detail[k], d[15:0])
    @(posedge clk_sys);
    #1 clear_faults = 1'b1;
    @(posedge clk_sys);
    #1 clear_faults = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("invalid cleared", 1'b0, inv_cmd)
    `CHK("alert released", 1'b1, alert_n)
    end_of_test();
  end
endmodule // tb_top
